// ### adc_run_control_sequencer.sv
// Run-control sequencer: restart, single shot, reset, standby, port pins
// ------------------------------------------------------------------
// ------------------------------------------------------------------
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

module adc_run_control_sequencer #(
  parameter int SETTLE_CYCLES = run_ctl_pkg::SETTLE_CYC  // Settling count, shortenable
) (
  input wire logic i_clk_sys,                  // 125 MHz clock
  input wire logic i_rst,                      // Synchronous reset, active high
  input wire logic i_ce,                       // Clock enable, freezes state when low
  input wire run_ctl_pkg::pins_s i_pins,       // Asynchronous control pins
  input wire logic i_s_axi_awvalid,            // Write address valid
  output logic o_s_axi_awready,                // Write address ready
  input wire logic [7:0] i_s_axi_awaddr,       // Write address
  input wire logic i_s_axi_wvalid,             // Write data valid
  output logic o_s_axi_wready,                 // Write data ready
  input wire logic [31:0] i_s_axi_wdata,       // Write data
  input wire logic [3:0] i_s_axi_wstrb,        // Write strobes
  output logic o_s_axi_bvalid,                 // Write response valid
  input wire logic i_s_axi_bready,             // Write response ready
  output logic [1:0] o_s_axi_bresp,            // Write response
  input wire logic i_s_axi_arvalid,            // Read address valid
  output logic o_s_axi_arready,                // Read address ready
  input wire logic [7:0] i_s_axi_araddr,       // Read address
  output logic o_s_axi_rvalid,                 // Read data valid
  input wire logic i_s_axi_rready,             // Read data ready
  output logic [31:0] o_s_axi_rdata,           // Read data
  output logic [1:0] o_s_axi_rresp,            // Read response
  output logic o_done_n,                       // Conversion done, active low
  output logic o_filter_clr,                   // Filter and modulator held cleared
  output logic o_sampling,                     // Modulator gathering samples
  output logic o_mclk_run,                     // Clock output running
  output logic [1:0] o_port_out                // General-purpose output pins
);
  import run_ctl_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  pins_s sync1_reg;                            // First stage, read by second only
  pins_s sync2_reg;                            // Second stage, safe to use
  logic restart_d_reg;                         // Previous restart level
  logic restart_rise;                          // Restart released this cycle
  logic restart_fall;                          // Restart asserted this cycle
  logic hard_rst;                              // Reset pin or system reset

  // Two-flop capture; pins idle high
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
      restart_d_reg <= 1'b1;
    end else if (i_ce) begin
      sync1_reg <= i_pins;
      sync2_reg <= sync1_reg;
      restart_d_reg <= sync2_reg.restart_n;
    end
  end

  assign restart_fall = restart_d_reg & ~sync2_reg.restart_n;
  assign restart_rise = ~restart_d_reg & sync2_reg.restart_n;
  assign hard_rst = i_rst | ~sync2_reg.reset_n;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0] mode_reg;                       // Mode register
  logic [31:0] data_reg;                       // Conversion result
  logic [31:0] sample_reg;                     // Latest sample from modulator side
  logic first_access_reg;                      // Next write selects register
  logic standby;                               // Device in standby
  logic [2:0] mode_sel;                        // operating_mode_sel field
  logic wr_fire;                               // Write address and data both present
  logic rd_fire;                               // Read accepted
  logic conv_end;                              // Conversion finishing this cycle
  logic single_end;                            // Single conversion finishing

  assign mode_sel = mode_reg[MODE_SEL_LSB +: 3];
  assign standby = ~sync2_reg.standby_n | (mode_sel == MODE_STANDBY_INDICATOR);

  // Byte-enable merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Writes are taken only when both channels present, no response pending
  assign wr_fire = i_s_axi_awvalid & i_s_axi_wvalid & ~o_s_axi_bvalid;
  assign rd_fire = i_s_axi_arvalid & ~o_s_axi_rvalid;

  // Mode register; restart does not touch it, reset pin restores it
  always_ff @(posedge i_clk_sys) begin
    if (hard_rst) begin
      mode_reg <= MODE_RST;
    end else if (i_ce) begin
      if (wr_fire && i_s_axi_awaddr == MODE_OFS) begin
        mode_reg <= merge(mode_reg, i_s_axi_wdata, i_s_axi_wstrb);
      end else if (single_end) begin
        mode_reg[MODE_SEL_LSB +: 3] <= MODE_IDLE;
      end
    end
  end

  // Sample input register, written by the modulator model over the bus
  always_ff @(posedge i_clk_sys) begin
    if (hard_rst) begin
      sample_reg <= DATA_RST;
    end else if (i_ce && wr_fire && i_s_axi_awaddr == SAMPLE_OFS) begin
      sample_reg <= merge(sample_reg, i_s_axi_wdata, i_s_axi_wstrb);
    end
  end

  // Result register; standby never clears it
  always_ff @(posedge i_clk_sys) begin
    if (hard_rst) begin
      data_reg <= DATA_RST;
    end else if (i_ce && conv_end) begin
      data_reg <= sample_reg;
    end
  end

  // Serial pointer state: first write after reset is the pointer write
  always_ff @(posedge i_clk_sys) begin
    if (hard_rst) begin
      first_access_reg <= 1'b1;
    end else if (i_ce && wr_fire) begin
      first_access_reg <= 1'b0;
    end
  end

  // Write response channel; reset pin drops accesses
  always_ff @(posedge i_clk_sys) begin
    if (hard_rst) begin
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= 2'h0;
    end else if (i_ce) begin
      if (wr_fire) begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= (i_s_axi_awaddr == MODE_OFS || i_s_axi_awaddr == SAMPLE_OFS)
                         ? 2'h0 : 2'h2;        // SLVERR on read-only or unmapped
      end else if (i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Ready strobes pulse one cycle after the accepting cycle
  always_ff @(posedge i_clk_sys) begin
    if (hard_rst) begin
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      o_s_axi_arready <= 1'b0;
    end else if (i_ce) begin
      o_s_axi_awready <= wr_fire & ~o_s_axi_awready;
      o_s_axi_wready <= wr_fire & ~o_s_axi_wready;
      o_s_axi_arready <= rd_fire & ~o_s_axi_arready;
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,                           // Filter held cleared
    ST_SETTLE = 2'b01,                         // Gathering, waiting for settling
    ST_RUN = 2'b10,                            // Settled, continuous output
    ST_IDLE = 2'b11                            // Idle or standby, no conversion
  } seq_e;

  seq_e state_reg;                             // Sequencer state
  seq_e state_next;                            // Next state
  logic [31:0] cnt_reg;                        // Settling counter
  logic done_n_reg;                            // Conversion-done flag, active low
  logic settle_reg;                            // filter_settling_flag, high = unsettled
  logic single_arm_reg;                        // A single conversion is in progress
  logic mode_single_wr;                        // Software wrote code 0,1,0

  assign mode_single_wr = wr_fire && i_s_axi_awaddr == MODE_OFS && i_s_axi_wstrb[0] &&
                          i_s_axi_wdata[MODE_SEL_LSB +: 3] == MODE_SINGLE;
  // Settling count reached while in ST_SETTLE
  assign conv_end = (state_reg == ST_SETTLE) && (cnt_reg == 32'(SETTLE_CYCLES - 1));
  assign single_end = conv_end & single_arm_reg;

  // Next-state decode; restart overrides everything, standby overrides all but restart
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_HOLD: begin
        if (sync2_reg.restart_n) begin
          state_next = standby ? ST_IDLE : ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (single_end) begin
          state_next = ST_IDLE;
        end else if (conv_end) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        state_next = ST_RUN;
      end
      ST_IDLE: begin
        if (!standby && (mode_sel == MODE_CONT || mode_single_wr)) begin
          state_next = ST_SETTLE;
        end
      end
      default: begin
        state_next = ST_HOLD;
      end
    endcase
    if (!sync2_reg.restart_n) begin
      state_next = ST_HOLD;
    end else if (standby) begin
      state_next = ST_IDLE;
    end else if (mode_single_wr && state_reg != ST_HOLD) begin
      state_next = ST_SETTLE;
    end
  end

  // State and settling counter
  always_ff @(posedge i_clk_sys) begin
    if (hard_rst) begin
      state_reg <= ST_SETTLE;
      cnt_reg <= 32'h0000_0000;
    end else if (i_ce) begin
      state_reg <= state_next;
      if (state_next != ST_SETTLE || state_reg != ST_SETTLE || restart_rise) begin
        cnt_reg <= 32'h0000_0000;              // count from common edge
      end else begin
        cnt_reg <= cnt_reg + 32'h0000_0001;
      end
    end
  end

  // Single-shot arm: set by code write or restart release in single mode
  always_ff @(posedge i_clk_sys) begin
    if (hard_rst) begin
      single_arm_reg <= 1'b0;
    end else if (i_ce) begin
      if (mode_single_wr || (restart_rise && mode_sel == MODE_SINGLE)) begin
        single_arm_reg <= 1'b1;
      end else if (single_end || standby || restart_fall) begin  // restart aborts shot
        single_arm_reg <= 1'b0;
      end
    end
  end

  // Done and settling flags: standby or restart set them high, result clears them
  always_ff @(posedge i_clk_sys) begin
    if (hard_rst) begin
      done_n_reg <= 1'b1;
      settle_reg <= 1'b1;
    end else if (i_ce) begin
      if (conv_end) begin
        done_n_reg <= 1'b0;
        settle_reg <= 1'b0;
      end else if (standby || !sync2_reg.restart_n) begin
        done_n_reg <= 1'b1;
        settle_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel; served in every mode including standby
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (hard_rst) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= 2'h0;
    end else if (i_ce) begin
      if (rd_fire) begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rresp <= 2'h0;
        case (i_s_axi_araddr)
          MODE_OFS: o_s_axi_rdata <= mode_reg;
          STATUS_OFS: o_s_axi_rdata <= {28'h0, ~sync2_reg.restart_n, standby,
                                         settle_reg, done_n_reg};
          DATA_OFS: o_s_axi_rdata <= data_reg;
          SERIAL_OFS: o_s_axi_rdata <= {31'h0, first_access_reg};
          SAMPLE_OFS: o_s_axi_rdata <= sample_reg;
          default: begin
            o_s_axi_rdata <= 32'h0000_0000;
            o_s_axi_rresp <= 2'h2;             // Unmapped address
          end
        endcase
      end else if (i_s_axi_rready) begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  // Clock output runs regardless of reset or standby; only system reset stops it
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_mclk_run <= 1'b0;
    end else begin
      o_mclk_run <= 1'b1;
    end
  end

  // Status pins follow the sequencer; port pins follow the mode register
  always_ff @(posedge i_clk_sys) begin
    if (hard_rst) begin
      o_done_n <= 1'b1;
      o_filter_clr <= 1'b1;
      o_sampling <= 1'b0;
      o_port_out <= 2'h0;
    end else if (i_ce) begin
      o_done_n <= (conv_end) ? 1'b0 : ((standby || !sync2_reg.restart_n) ? 1'b1 : done_n_reg);
      o_filter_clr <= (state_next == ST_HOLD);
      o_sampling <= (state_next == ST_SETTLE) || (state_next == ST_RUN);
      o_port_out <= mode_reg[PORT_EN_BIT] ? {mode_reg[PORT_B1_BIT], mode_reg[PORT_B0_BIT]}
                                          : 2'h0;
    end
  end

endmodule
`default_nettype wire

// ### host_model.sv
// Host partner: control pins and AXI4-Lite master
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic i_clk,  // Clock
  output run_ctl_pkg::pins_s o_pins,  // Control pins
  output logic o_awvalid,  // Write addr valid
  output logic [7:0] o_awaddr,  // Write addr
  output logic o_wvalid,  // Write data valid
  output logic [31:0] o_wdata,  // Write data
  output logic o_bready,  // Response accept
  output logic o_arvalid,  // Read addr valid
  output logic [7:0] o_araddr,  // Read addr
  output logic o_rready,  // Read accept
  input wire logic i_awready,  // Write addr taken
  input wire logic i_wready,  // Write data taken
  input wire logic i_bvalid,  // Write answer
  input wire logic [1:0] i_bresp,  // Write code
  input wire logic i_arready,  // Read addr taken
  input wire logic i_rvalid,  // Read answer
  input wire logic [31:0] i_rdata,  // Read data
  input wire logic [1:0] i_rresp  // Read code
);
  initial begin
    o_pins = 3'b111;  // All pins idle high
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
    {o_awaddr, o_araddr, o_wdata} = 48'h0;
  end
  // Pin change just after an edge; restart pulse shared by all devices
  task automatic set_pins(input run_ctl_pkg::pins_s p);
    @(posedge i_clk);
    o_pins <= p;
  endtask
  // One write; released payload shows inverse so stale data is never trusted
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_go, w_go;
    @(posedge i_clk);
    aw_go = 1'b1;
    w_go = 1'b1;
    o_awaddr <= a;
    o_wdata <= d;
    {o_awvalid, o_wvalid, o_bready} <= 3'b111;
    do begin
      @(posedge i_clk);
      if (aw_go && i_awready) begin
        aw_go = 1'b0;
        o_awvalid <= 1'b0;
        o_awaddr <= ~a;
      end
      if (w_go && i_wready) begin
        w_go = 1'b0;
        o_wvalid <= 1'b0;
        o_wdata <= ~d;
      end
    end while (!i_bvalid);
    r = i_bresp;
    o_bready <= 1'b0;
  endtask
  logic slow_rr = 1'b0;  // Alternate reads raise rready late, so answer hold is exercised
  // One read, address released when taken, data taken at the rready handshake
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_go, r_on, fin;
    @(posedge i_clk);
    slow_rr = ~slow_rr;
    ar_go = 1'b1;
    r_on = ~slow_rr;
    o_araddr <= a;
    o_arvalid <= 1'b1;
    o_rready <= r_on;
    do begin
      @(posedge i_clk);
      fin = r_on && i_rvalid;
      if (ar_go && i_arready) begin
        ar_go = 1'b0;
        o_arvalid <= 1'b0;
        o_araddr <= ~a;
      end
      if (!r_on && i_rvalid) begin
        r_on = 1'b1;
        o_rready <= 1'b1;
      end
    end while (!fin);
    d = i_rdata;
    r = i_rresp;
    o_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### run_ctl_pkg.sv
// Package: register map, field layout and timing constants of the run-control sequencer
package run_ctl_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets (AXI4-Lite, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_OFS = 8'h00;     // Mode register
  localparam logic [7:0] STATUS_OFS = 8'h04;   // Status register
  localparam logic [7:0] DATA_OFS = 8'h08;     // Conversion result
  localparam logic [7:0] SERIAL_OFS = 8'h0C;   // Serial-port pointer state
  localparam logic [7:0] SAMPLE_OFS = 8'h10;   // Sample input (from modulator model)

  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int MODE_SEL_LSB = 0;             // operating_mode_sel [2:0]
  localparam int PORT_EN_BIT = 4;              // port_output_enable
  localparam int PORT_B0_BIT = 5;              // port_out_bit0
  localparam int PORT_B1_BIT = 6;              // port_out_bit1
  localparam logic [31:0] MODE_RST = 32'h0000_0000;  // Mode register reset value

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int ST_DONE_N_BIT = 0;            // Conversion-done, active low
  localparam int ST_SETTLE_BIT = 1;            // filter_settling_flag
  localparam int ST_STANDBY_INDICATOR_BIT = 2;              // standby_indicator
  localparam int ST_RESTART_BIT = 3;           // Filter held in restart

  // ----------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_CONT = 3'h0,                          // Continuous conversion
    MODE_SINGLE = 3'h2,                        // Single conversion (0,1,0)
    MODE_STANDBY_INDICATOR = 3'h3,                          // Standby (0,1,1)
    MODE_IDLE = 3'h1                           // Idle
  } op_mode_e;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;                // System clock rate
  localparam int SETTLE_US = 40;               // Filter settling time, microseconds
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;  // Settling in cycles
  localparam logic [31:0] DATA_RST = 32'h0000_0000;  // Data register reset value

  // Control pins after synchronisation
  typedef struct packed {
    logic restart_n;                           // Filter restart, active low
    logic reset_n;                             // Hard reset, active low
    logic standby_n;                           // Standby, active low
  } pins_s;

endpackage

// ### run_ctl_sva.sv
// Checker: port-level assertions of the run-control sequencer
`timescale 1ns/10ps
`default_nettype none
module run_ctl_sva #(
  parameter int SETTLE_CYCLES = 8  // Settling count
) (
  input wire logic i_clk_sys,  // Clock
  input wire logic i_rst,  // Reset
  input wire logic i_ce,  // Clock enable
  input wire run_ctl_pkg::pins_s i_pins,  // Control pins
  input wire logic i_s_axi_arvalid,  // Read request
  input wire logic i_s_axi_rready,  // Read accept
  input wire logic o_s_axi_awready,  // Write addr ready
  input wire logic o_s_axi_arready,  // Read addr ready
  input wire logic o_s_axi_rvalid,  // Read answer
  input wire logic o_done_n,  // Done, active low
  input wire logic o_filter_clr,  // Filter cleared
  input wire logic o_sampling,  // Sampling
  input wire logic o_mclk_run  // Clock output running
);
  import run_ctl_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // Helper: cycles spent sampling
  // ----------------------------------------
  int unsigned run_cnt;  // Restarts whenever sampling stops
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !o_sampling) run_cnt <= 0;
    else if (i_ce) run_cnt <= run_cnt + 1;
  end
  // Four cycles cover the two-flop pin synchroniser
  sequence s_clr_held; (i_ce && !i_pins.restart_n)[*4]; endsequence
  sequence s_nrst_held; (i_ce && !i_pins.reset_n)[*4]; endsequence
  sequence s_rd_req; i_pins.reset_n[*4] ##0 (i_ce && i_s_axi_arvalid && !o_s_axi_rvalid);
  endsequence
  property p_clr_hold; s_clr_held |-> o_filter_clr && !o_sampling; endproperty
  property p_nrst; s_nrst_held |-> o_done_n && o_mclk_run && !o_sampling; endproperty
  property p_nrst_bus; s_nrst_held |-> !o_s_axi_awready && !o_s_axi_arready; endproperty
  property p_standby_indicator; (i_ce && !i_pins.standby_n)[*4] |-> o_done_n; endproperty
  property p_settle; $fell(o_done_n) |-> run_cnt >= SETTLE_CYCLES - 1; endproperty
  property p_mclk; !$past(i_rst) |-> o_mclk_run; endproperty
  property p_rd_ans; s_rd_req |=> o_s_axi_rvalid && o_s_axi_arready; endproperty
  property p_rhold; o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid; endproperty
  a_clr_hold: assert property (p_clr_hold) else $error("filter not held");
  a_nrst: assert property (p_nrst) else $error("reset pin state wrong");
  a_nrst_bus: assert property (p_nrst_bus) else $error("bus served in reset");
  a_standby_indicator: assert property (p_standby_indicator) else $error("done low in standby");
  a_settle: assert property (p_settle) else $error("result before settling");
  a_mclk: assert property (p_mclk) else $error("clock output stopped");
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
endmodule
bind adc_run_control_sequencer run_ctl_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_sva (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce), .i_pins(i_pins),
  .i_s_axi_arvalid(i_s_axi_arvalid), .i_s_axi_rready(i_s_axi_rready),
  .o_s_axi_awready(o_s_axi_awready), .o_s_axi_arready(o_s_axi_arready),
  .o_s_axi_rvalid(o_s_axi_rvalid), .o_done_n(o_done_n), .o_filter_clr(o_filter_clr),
  .o_sampling(o_sampling), .o_mclk_run(o_mclk_run));
`default_nettype wire

// ### testbench.sv
// Testbench: run-control sequencer against a behavioural model
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench;
  import run_ctl_pkg::*;
  localparam int SETTLE = 8;  // Shortened settling count
  logic i_clk_sys = 1'b0, i_rst = 1'b1, i_ce = 1'b1;  // Clock, reset, enable
  pins_s pins;  // Control pins from host
  logic awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr, done_n, f_clr, smp, mclk;
  logic [7:0] awa, ara;  // Addresses
  logic [31:0] wd, rdat, v;  // Data
  logic [1:0] bresp, rresp, resp, port;  // Codes and port pins
  logic [3:0] wstrb = 4'hF;  // Write byte strobes
  int failures = 0, checks_done = 0, cyc = 0, exp_data = 0;
  int q[$];  // Samples awaiting a conversion
  always #4 i_clk_sys = ~i_clk_sys;
  host_model host (.i_clk(i_clk_sys), .o_pins(pins), .o_awvalid(awv), .o_awaddr(awa),
    .o_wvalid(wv), .o_wdata(wd), .o_bready(br), .o_arvalid(arv), .o_araddr(ara),
    .o_rready(rr), .i_awready(awr), .i_wready(wr_rdy), .i_bvalid(bv), .i_bresp(bresp),
    .i_arready(arr), .i_rvalid(rv), .i_rdata(rdat), .i_rresp(rresp));
  adc_run_control_sequencer #(.SETTLE_CYCLES(SETTLE)) DUT (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_ce(i_ce), .i_pins(pins), .i_s_axi_awvalid(awv),
    .o_s_axi_awready(awr), .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv),
    .o_s_axi_wready(wr_rdy), .i_s_axi_wdata(wd), .i_s_axi_wstrb(wstrb),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(br), .o_s_axi_bresp(bresp),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rr), .o_s_axi_rdata(rdat), .o_s_axi_rresp(rresp),
    .o_done_n(done_n), .o_filter_clr(f_clr), .o_sampling(smp), .o_mclk_run(mclk),
    .o_port_out(port));
  // Hang guard: whole run is a few hundred cycles
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a);
    host.rd(a, v, resp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.wr(a, d, resp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  // Read until the masked value matches, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    do begin
      rd(a);
      n++;
    end while ((v & m) !== e && n < 40);
  endtask
  initial begin
    void'($urandom(35043));
    repeat (10) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rd(MODE_OFS); `CHK(v, MODE_RST)
    poll(STATUS_OFS, 32'h3, 32'h0); `CHK(v[1:0], 2'b00)
    rd(DATA_OFS); `CHK(v, DATA_RST)
    rd(SERIAL_OFS); `CHK(v[0], 1'b1)
    $display("Test reset defaults done");
    wr(MODE_OFS, MODE_IDLE);
    rd(SERIAL_OFS); `CHK(v[0], 1'b0)
    // Back-to-back single shots with random samples
    for (int i = 0; i < 2; i++) begin
      q.push_back($urandom);
      wr(SAMPLE_OFS, q[$]);
      wr(MODE_OFS, MODE_SINGLE);
      rd(DATA_OFS); `CHK(v, exp_data)
      poll(MODE_OFS, 32'h7, MODE_IDLE); `CHK(v[2:0], MODE_IDLE)
      exp_data = q.pop_front();
      rd(DATA_OFS); `CHK(v, exp_data)
    end
    $display("Test single shot done");
    host.set_pins(3'b110);
    settle(5);
    rd(STATUS_OFS); `CHK(v[2:0], 3'b111)
    rd(DATA_OFS); `CHK(v, exp_data)
    host.set_pins(3'b111);
    settle(5);
    rd(MODE_OFS); `CHK(v[2:0], MODE_IDLE)
    rd(STATUS_OFS); `CHK(v[1:0], 2'b11)
    wr(MODE_OFS, MODE_STANDBY_INDICATOR);
    rd(STATUS_OFS); `CHK(v[2], 1'b1)
    wr(MODE_OFS, MODE_CONT);
    poll(STATUS_OFS, 32'h3, 32'h0); `CHK(v[1:0], 2'b00)
    $display("Test standby done");
    @(posedge i_clk_sys);
    i_ce <= 1'b0;
    host.set_pins(3'b011);
    settle(5);
    `CHK({f_clr, smp}, 2'b01)
    @(posedge i_clk_sys);
    i_ce <= 1'b1;
    settle(5);
    `CHK({f_clr, smp}, 2'b10)
    rd(MODE_OFS); `CHK(v[2:0], MODE_CONT)
    rd(STATUS_OFS); `CHK(v[3], 1'b1)
    host.set_pins(3'b111);
    settle(4);
    `CHK({f_clr, smp}, 2'b01)
    poll(STATUS_OFS, 32'h1, 32'h0); `CHK(v[0], 1'b0)
    $display("Test restart done");
    for (int i = 0; i < 4; i++) begin
      wr(MODE_OFS, (i << 5) | 32'h11);
      settle(2);
      `CHK(port, i[1:0])
    end
    wr(MODE_OFS, 32'h71);
    wr(MODE_OFS, 32'h61);
    settle(2);
    `CHK(port, 2'b00)
    wr(MODE_OFS, 32'h71);
    host.set_pins(3'b101);
    settle(5);
    `CHK({done_n, mclk, port}, 4'b1100)
    host.set_pins(3'b111);
    settle(4);
    rd(MODE_OFS); `CHK(v, MODE_RST)
    rd(SERIAL_OFS); `CHK(v[0], 1'b1)
    wstrb <= 4'h1;
    wr(MODE_OFS, 32'hFFFF_FF71);
    @(posedge i_clk_sys);
    wstrb <= 4'hE;
    wr(MODE_OFS, 32'h0000_0000);
    @(posedge i_clk_sys);
    wstrb <= 4'hF;
    settle(2);
    `CHK(port, 2'b11)
    rd(MODE_OFS); `CHK(v, 32'h0000_0071)
    $display("Test port and reset pin done");
    rd(8'h20); `CHK(resp, 2'b10)
    wr(DATA_OFS, 32'h5A5A_0000); `CHK(resp, 2'b10)
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    settle(3);
    `CHK({done_n, mclk}, 2'b10)
    @(posedge i_clk_sys);
    i_rst <= 1'b0;
    poll(STATUS_OFS, 32'h1, 32'h0); `CHK(v[0], 1'b0)
    $display("Test bus errors and reset done");
    finish_test();
  end
endmodule
`default_nettype wire
